// [design/hbse_pkg.sv]
package hbse_pkg;
   // ----------------------------------------
   // Frame layout
   // ----------------------------------------
   localparam int         FRAME_BITS = 16;
   localparam int         CNT_W      = 5;
   localparam logic [4:0] LAST_BIT   = 5'h0f;
   localparam logic [4:0] OVER_BIT   = 5'h10;
   localparam logic [3:0] TOP_BIT    = 4'hf;
   localparam int         WRITE_POS  = 15;
   localparam int         SEL_MSB    = 14;
   localparam int         SEL_LSB    = 10;
   localparam int         ADDR_MSB   = 15;
   localparam int         ADDR_LSB   = 8;
   localparam int         DATA_MSB   = 7;
   localparam int         SEL_W      = 5;
   localparam int         REG_W      = 8;

   // ----------------------------------------
   // Register bank
   // ----------------------------------------
   localparam int NUM_CTRL    = 3;
   localparam int NUM_STAT    = 4;
   localparam int NUM_BRIDGES = 12;
   localparam int OC_FLAGS    = 8;
   localparam int OL_FLAGS    = 24;
   localparam int UPPER_OFS   = 1;
   localparam int LOWER_OFS   = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] STAT_RESET = 8'h00;
   // Select codes: three enable groups, then overcurrent 9-12
   // and open load 1-4, 5-8, 9-12
   localparam logic [4:0] CTRL_SEL [NUM_CTRL] =
      '{5'h00, 5'h10, 5'h08};
   localparam logic [4:0] STAT_SEL [NUM_STAT] =
      '{5'h1e, 5'h01, 5'h11, 5'h09};
endpackage : hbse_pkg

// [design/hbse_sync.sv]
`timescale 1ns/1ns
module hbse_sync #(
   parameter int WIDTH  = 1,
   parameter int STAGES = 2
)
(
   // Destination clock
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Levels
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   if (STAGES < 2)
   begin : gCheck
      $error("hbse_sync needs at least two stages");
   end

   logic [STAGES-1:0][WIDTH-1:0] stage_q;
   logic [STAGES-1:0][WIDTH-1:0] stage_d;

   // Each stage only feeds the next one
   always_comb
   begin
      stage_d = {stage_q[STAGES-2:0], din};
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         stage_q <= '0;
      else
         stage_q <= stage_d;
   end

   assign dout = stage_q[STAGES-1];
endmodule // hbse_sync

// [design/hbse_spi_link.sv]
`timescale 1ns/1ns
module hbse_spi_link
(
   // Link pins
   input  wire logic        spiClk,
   input  wire logic        spiCs_n,
   input  wire logic        spiDataIn,
   output logic             spiDataOut,
   output logic             spiDataOutOe,
   // Towards the register bank
   input  wire logic        reset_n,
   input  wire logic [15:0] txWord,
   output logic      [15:0] frameWord,
   output logic             goodTgl,
   output logic             badTgl
);
   import hbse_pkg::*;

   logic [CNT_W-1:0]      bitCnt_q;
   logic [CNT_W-1:0]      bitCnt_d;
   logic [FRAME_BITS-1:0] shift_q;
   logic [FRAME_BITS-1:0] shift_d;
   logic [FRAME_BITS-1:0] frame_q;
   logic [FRAME_BITS-1:0] frame_d;
   logic                  good_q;
   logic                  good_d;
   logic                  bad_q;
   logic                  bad_d;

   // ----------------------------------------
   // Bit counting, sampled on rising clock
   // ----------------------------------------
   always_comb
   begin
      bitCnt_d = bitCnt_q;
      if (bitCnt_q <= OVER_BIT)
         bitCnt_d = bitCnt_q + 5'h01;
      shift_d = {shift_q[FRAME_BITS-2:0], spiDataIn};
      frame_d = frame_q;
      good_d  = good_q;
      bad_d   = bad_q;
      if (bitCnt_q == LAST_BIT)
      begin
         frame_d = shift_d;
         good_d  = ~good_q;
      end
      if (bitCnt_q == OVER_BIT)
         bad_d = ~bad_q;
   end

   // Chip select high clears the bit count and shift register; the clock may be stopped
   always_ff @(posedge spiClk or posedge spiCs_n)
   begin
      if (spiCs_n)
      begin
         bitCnt_q <= '0;
         shift_q  <= '0;
      end
      else
      begin
         bitCnt_q <= bitCnt_d;
         shift_q  <= shift_d;
      end
   end

   // Toggles outlive the frame so the bank can see them later
   always_ff @(posedge spiClk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         frame_q <= '0;
         good_q  <= 1'b0;
         bad_q   <= 1'b0;
      end
      else
      begin
         frame_q <= frame_d;
         good_q  <= good_d;
         bad_q   <= bad_d;
      end
   end

   // ----------------------------------------
   // Response, most significant bit first
   // ----------------------------------------
   // txWord is held still by the bank while a frame shifts out
   assign spiDataOut   = (bitCnt_q < OVER_BIT) ?
                         txWord[TOP_BIT - bitCnt_q[3:0]] : 1'b0;
   assign spiDataOutOe = ~spiCs_n;
   assign frameWord    = frame_q;
   assign goodTgl      = good_q;
   assign badTgl       = bad_q;
endmodule // hbse_spi_link

// [design/hbse_regs.sv]
`timescale 1ns/1ns
module hbse_regs
(
   // System
   input  wire logic                             clk,
   input  wire logic                             reset_n,
   // Serial link
   input  wire logic                             spiClk,
   input  wire logic                             spiCs_n,
   input  wire logic                             spiDataIn,
   output logic                                  spiDataOut,
   output logic                                  spiDataOutOe,
   // Fault detectors
   input  wire logic [hbse_pkg::OC_FLAGS-1:0]    ocEvent,
   input  wire logic [hbse_pkg::OL_FLAGS-1:0]    olEvent,
   // Bridge drive
   output logic      [hbse_pkg::NUM_BRIDGES-1:0] upperSwitchOn,
   output logic      [hbse_pkg::NUM_BRIDGES-1:0] lowerSwitchOn
);
   import hbse_pkg::*;

   localparam int SYNC_W = 3 + OC_FLAGS + OL_FLAGS;

   // The pair decode below needs two enables for every bridge
   if (NUM_CTRL * REG_W != 2 * NUM_BRIDGES)
   begin : gPairCheck
      $error("enable groups do not match the bridge count");
   end

   // Each status register takes one byte of detector flags
   if (OC_FLAGS != REG_W || OL_FLAGS != (NUM_STAT - 1) * REG_W)
   begin : gFlagCheck
      $error("detector widths do not match the status registers");
   end

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [FRAME_BITS-1:0]             frameWord;
   logic [FRAME_BITS-1:0]             txWord;
   logic                              goodTgl;
   logic                              badTgl;
   logic [SYNC_W-1:0]                 syncIn;
   logic [SYNC_W-1:0]                 syncOut;
   logic                              csnS;
   logic                              goodS;
   logic                              badS;
   logic [OC_FLAGS-1:0]               ocS;
   logic [OL_FLAGS-1:0]               olS;

   logic                              csnPrev_q;
   logic                              csnPrev_d;
   logic                              goodSeen_q;
   logic                              goodSeen_d;
   logic                              badSeen_q;
   logic                              badSeen_d;
   logic [NUM_CTRL-1:0][REG_W-1:0]    ctrl_q;
   logic [NUM_CTRL-1:0][REG_W-1:0]    ctrl_d;
   logic [NUM_STAT-1:0][REG_W-1:0]    stat_q;
   logic [NUM_STAT-1:0][REG_W-1:0]    stat_d;
   logic [NUM_STAT-1:0][REG_W-1:0]    statSet;
   logic [NUM_STAT-1:0][REG_W-1:0]    statClr;
   logic [REG_W-1:0]                  readByte_q;
   logic [REG_W-1:0]                  readByte_d;
   logic [REG_W-1:0]                  echo_q;
   logic [REG_W-1:0]                  echo_d;
   logic [NUM_BRIDGES-1:0]            upperOn_q;
   logic [NUM_BRIDGES-1:0]            upperOn_d;
   logic [NUM_BRIDGES-1:0]            lowerOn_q;
   logic [NUM_BRIDGES-1:0]            lowerOn_d;
   logic [NUM_CTRL*REG_W-1:0]         ctrlFlat;

   logic                              csnRise;
   logic                              frameOk;
   logic                              isWrite;
   logic [SEL_W-1:0]                  sel;
   logic [REG_W-1:0]                  wrData;

   // ----------------------------------------
   // Link front end
   // ----------------------------------------
   hbse_spi_link hbse_spi_link_inst
   (
      .spiClk       (spiClk),
      .spiCs_n      (spiCs_n),
      .spiDataIn    (spiDataIn),
      .spiDataOut   (spiDataOut),
      .spiDataOutOe (spiDataOutOe),
      .reset_n      (reset_n),
      .txWord       (txWord),
      .frameWord    (frameWord),
      .goodTgl      (goodTgl),
      .badTgl       (badTgl)
   );

   // ----------------------------------------
   // Crossing into the system clock
   // ----------------------------------------
   // Chip select and both toggles share one depth, so a frame's
   // toggle is always seen no later than its closing edge.
   // Select travels inverted: a cleared synchroniser then reads
   // as idle and no false closing edge follows reset
   assign syncIn = {~spiCs_n, goodTgl, badTgl, ocEvent, olEvent};

   hbse_sync #(
      .WIDTH  (SYNC_W),
      .STAGES (2)
   ) hbse_sync_inst
   (
      .clk     (clk),
      .reset_n (reset_n),
      .din     (syncIn),
      .dout    (syncOut)
   );

   assign {csnS, goodS, badS, ocS, olS} =
      {~syncOut[SYNC_W-1], syncOut[SYNC_W-2:0]};

   // ----------------------------------------
   // Frame acceptance
   // ----------------------------------------
   assign csnRise = csnS & ~csnPrev_q;
   // Exactly sixteen bits: one new good toggle, no overrun toggle
   assign frameOk = csnRise & (goodS != goodSeen_q)
                    & (badS == badSeen_q);
   assign isWrite = frameWord[WRITE_POS];
   assign sel     = frameWord[SEL_MSB:SEL_LSB];
   assign wrData  = frameWord[DATA_MSB:0];

   // ----------------------------------------
   // Status sources
   // ----------------------------------------
   // Detector levels set flags while they stand
   assign statSet[0] = ocS;
   for (genvar k = 1; k < NUM_STAT; k++)
   begin : gOpenLoad
      assign statSet[k] = olS[(k-1)*REG_W +: REG_W];
   end

   // ----------------------------------------
   // Register bank next state
   // ----------------------------------------
   always_comb
   begin
      csnPrev_d  = csnS;
      goodSeen_d = goodSeen_q;
      badSeen_d  = badSeen_q;
      ctrl_d     = ctrl_q;
      readByte_d = readByte_q;
      echo_d     = echo_q;
      statClr    = '0;
      if (csnRise)
      begin
         goodSeen_d = goodS;
         badSeen_d  = badS;
      end
      if (frameOk)
      begin
         echo_d     = frameWord[ADDR_MSB:ADDR_LSB];
         readByte_d = '0;
         for (int i = 0; i < NUM_CTRL; i++)
         begin
            if (sel == CTRL_SEL[i])
            begin
               readByte_d = ctrl_q[i];
               if (isWrite)
                  ctrl_d[i] = wrData;
            end
         end
         // Status is cleared by any access that returns it
         for (int j = 0; j < NUM_STAT; j++)
         begin
            if (sel == STAT_SEL[j])
            begin
               readByte_d = stat_q[j];
               statClr[j] = stat_q[j];
            end
         end
      end
      // A detector set in the clearing cycle wins
      for (int j = 0; j < NUM_STAT; j++)
      begin
         stat_d[j] = (stat_q[j] & ~statClr[j]) | statSet[j];
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         csnPrev_q  <= 1'b1;
         goodSeen_q <= 1'b0;
         badSeen_q  <= 1'b0;
         ctrl_q     <= {NUM_CTRL{CTRL_RESET}};
         stat_q     <= {NUM_STAT{STAT_RESET}};
         readByte_q <= '0;
         echo_q     <= '0;
      end
      else
      begin
         csnPrev_q  <= csnPrev_d;
         goodSeen_q <= goodSeen_d;
         badSeen_q  <= badSeen_d;
         ctrl_q     <= ctrl_d;
         stat_q     <= stat_d;
         readByte_q <= readByte_d;
         echo_q     <= echo_d;
      end
   end

   // Answer of the last accepted frame; it only moves after a
   // frame closes, so it is still while the next one shifts out
   assign txWord = {echo_q, readByte_q};

   // ----------------------------------------
   // Bridge decode and interlock
   // ----------------------------------------
   assign ctrlFlat = ctrl_q;

   for (genvar b = 0; b < NUM_BRIDGES; b++)
   begin : gBridge
      // Never both switches of one bridge, even for one cycle
      assign upperOn_d[b] = ctrlFlat[2*b+UPPER_OFS]
                            & ~ctrlFlat[2*b+LOWER_OFS];
      assign lowerOn_d[b] = ctrlFlat[2*b+LOWER_OFS]
                            & ~ctrlFlat[2*b+UPPER_OFS];
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         upperOn_q <= '0;
         lowerOn_q <= '0;
      end
      else
      begin
         upperOn_q <= upperOn_d;
         lowerOn_q <= lowerOn_d;
      end
   end

   assign upperSwitchOn = upperOn_q;
   assign lowerSwitchOn = lowerOn_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   logic started_q;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         started_q <= 1'b0;
      else
         started_q <= 1'b1;
   end

   reset_all_off_a: assert property (
      !started_q |-> ctrl_q == '0 && upperOn_q == '0
                     && lowerOn_q == '0)
      else $error("registers not cleared after reset");

   ctrl_hold_a: assert property (
      !(frameOk && isWrite) |=> $stable(ctrl_q))
      else $error("control changed without a write");

   read_keep_a: assert property (
      frameOk && !isWrite |=> $stable(ctrl_q))
      else $error("read altered a control register");

   write_first_a: assert property (
      frameOk && isWrite && sel == CTRL_SEL[0]
      |=> ctrl_q[0] == $past(wrData))
      else $error("write not loaded into group one");

   write_last_a: assert property (
      frameOk && isWrite && sel == CTRL_SEL[2]
      |=> ctrl_q[2] == $past(wrData) && $stable(ctrl_q[0]))
      else $error("write not loaded into group three");

   no_shoot_a: assert property (
      (upperOn_q & lowerOn_q) == '0)
      else $error("both switches of a bridge on");

   both_off_a: assert property (
      ctrl_q[1][1] && ctrl_q[1][0]
      |=> !upperOn_q[4] && !lowerOn_q[4])
      else $error("bridge five not off with both enables");

   drive_map_a: assert property (
      ctrl_q[0][7] && !ctrl_q[0][6] |=> upperOn_q[3] && !lowerOn_q[3])
      else $error("output four upper switch not on");

   group_off_a: assert property (
      ctrl_q[0] == '0 |=> upperOn_q[3:0] == '0 && lowerOn_q[3:0] == '0)
      else $error("cleared group one left a switch on");

   write_middle_a: assert property (
      frameOk && isWrite && sel == CTRL_SEL[1]
      |=> ctrl_q[1] == $past(wrData))
      else $error("write not loaded into group two");

   lower_map_a: assert property (
      ctrl_q[2][0] && !ctrl_q[2][1] |=> lowerOn_q[8] && !upperOn_q[8])
      else $error("output nine lower switch not on");

   read_answer_a: assert property (
      frameOk && !isWrite && sel == CTRL_SEL[1]
      |=> readByte_q == $past(ctrl_q[1]))
      else $error("read did not return group two");

   echo_addr_a: assert property (
      frameOk |=> echo_q[REG_W-1] == $past(isWrite)
                  && echo_q[REG_W-2 -: SEL_W] == $past(sel))
      else $error("answer does not echo the address byte");

   flag_set_a: assert property (
      statSet != '0 |=> (stat_q & $past(statSet)) == $past(statSet))
      else $error("detector did not set its flag");

   flag_keep_a: assert property (
      !frameOk |=> (stat_q & $past(stat_q)) == $past(stat_q))
      else $error("flag dropped without an access");
endmodule // hbse_regs

// [tb/hbse_spi_host.sv]
`timescale 1ns/1ns
// ----------------------------------------
// Host side of the serial link
// ----------------------------------------
module hbse_spi_host
(
   // Link pins
   output logic      spiClk,
   output logic      spiCs_n,
   output logic      spiDataIn,
   // Return line from the device
   input  wire logic spiDataOut,
   input  wire logic spiDataOutOe
);
   logic        misoLine;
   logic [15:0] rxWord;

   // Assumed pull-up while the device leaves the line released
   assign misoLine = spiDataOutOe ? spiDataOut : 1'b1;

   initial
   begin
      spiClk    = 1'b0;
      spiCs_n   = 1'b1;
      spiDataIn = 1'b0;
      rxWord    = 16'h0000;
   end

   // The host is the only writer of control bits
   // Clock stands low between frames; address byte goes first
   task automatic frame(input logic [15:0] word, input int nBits);
      begin
         spiCs_n = 1'b0;
         for (int i = 0; i < nBits; i++)
         begin
            // Bits past the sixteenth wrap round to the top of the word
            spiDataIn = word[(31 - i) % 16];
            #16 spiClk = 1'b1;
            rxWord = {rxWord[14:0], misoLine};
            #16 spiClk = 1'b0;
         end
         #16 spiCs_n = 1'b1;
         // Inverse rather than a stale bit once deselected
         spiDataIn = ~spiDataIn;
         #48;
      end
   endtask
endmodule // hbse_spi_host

// [tb/test_half_bridge_switch_enable_regs.sv]
`timescale 1ns/1ns
module test_half_bridge_switch_enable_regs;
   import hbse_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic                   clk;
   logic                   reset_n;
   logic                   spiClk;
   logic                   spiCs_n;
   logic                   spiDataIn;
   logic                   spiDataOut;
   logic                   spiDataOutOe;
   logic [OC_FLAGS-1:0]    ocEvent;
   logic [OL_FLAGS-1:0]    olEvent;
   logic [NUM_BRIDGES-1:0] upperSwitchOn;
   logic [NUM_BRIDGES-1:0] lowerSwitchOn;
   logic [REG_W-1:0]       shadow [NUM_CTRL];
   int                     error_cnt;
   int                     n_checks;

   hbse_regs hbse_regs_inst (
      .clk(clk), .reset_n(reset_n), .spiClk(spiClk), .spiCs_n(spiCs_n),
      .spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
      .spiDataOutOe(spiDataOutOe), .ocEvent(ocEvent), .olEvent(olEvent),
      .upperSwitchOn(upperSwitchOn), .lowerSwitchOn(lowerSwitchOn));

   hbse_spi_host hbse_spi_host_inst (
      .spiClk(spiClk), .spiCs_n(spiCs_n), .spiDataIn(spiDataIn),
      .spiDataOut(spiDataOut), .spiDataOutOe(spiDataOutOe));

   initial clk = 1'b0;
   always #4 clk = ~clk;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [23:0] expected();
      logic [11:0] up;
      logic [11:0] lo;
      up = 12'h000;
      lo = 12'h000;
      for (int i = 0; i < NUM_BRIDGES; i++)
      begin
         logic u;
         logic l;
         u = shadow[i/4][2*(i%4)+UPPER_OFS];
         l = shadow[i/4][2*(i%4)+LOWER_OFS];
         // Both requested means the bridge stays fully off
         up[i] = u & ~l;
         lo[i] = l & ~u;
      end
      return {up, lo};
   endfunction

   task automatic check(input string what, input logic [23:0] seen,
                        input logic [23:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Crossing into the system clock takes a few edges
   task automatic settle();
      repeat (12) @(posedge clk);
      #1;
   endtask

   task automatic write_reg(input int g, input logic [7:0] d);
      hbse_spi_host_inst.frame({1'b1, CTRL_SEL[g], 2'b01, d}, 16);
      shadow[g] = d;
      settle();
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      settle();
      check("outputs after reset", {upperSwitchOn, lowerSwitchOn},
            24'h000000);
   endtask

   task automatic t_groups();
      logic [7:0] pat [4];
      pat = '{8'hff, 8'hc9, 8'h99, 8'h66};
      for (int g = 0; g < NUM_CTRL; g++)
         for (int p = 0; p < 4; p++)
         begin
            write_reg(g, pat[p]);
            check("group outputs", {upperSwitchOn, lowerSwitchOn},
                  expected());
         end
   endtask

   task automatic t_read();
      logic [15:0] rd;
      logic [23:0] ans;
      for (int g = 0; g <= NUM_CTRL; g++)
      begin
         // A data byte of all ones must not land in a read
         rd = {1'b0, CTRL_SEL[g % NUM_CTRL], 2'b01, 8'hff};
         hbse_spi_host_inst.frame(rd, 16);
         // The answer to a frame comes out during the next one
         if (g > 0)
            check("read answer", {8'h00, hbse_spi_host_inst.rxWord},
                  ans);
         ans = {8'h00, rd[15:8], shadow[g % NUM_CTRL]};
      end
      settle();
      check("outputs after reads", {upperSwitchOn, lowerSwitchOn},
            expected());
   endtask

   task automatic t_partial();
      int n [3];
      n = '{8, 15, 17};
      // Short and overlong frames are both refused
      for (int k = 0; k < 3; k++)
      begin
         hbse_spi_host_inst.frame({1'b1, CTRL_SEL[1], 2'b01, 8'h00}, n[k]);
         settle();
         check("outputs after short frame", {upperSwitchOn, lowerSwitchOn},
               expected());
      end
   endtask

   task automatic t_status();
      logic [15:0] rd;
      logic [23:0] ans;
      for (int j = 0; j <= NUM_STAT; j++)
      begin
         rd = {1'b0, STAT_SEL[j % NUM_STAT], 2'b01, 8'h00};
         hbse_spi_host_inst.frame(rd, 16);
         if (j > 0)
            check("status answer", {8'h00, hbse_spi_host_inst.rxWord},
                  ans);
         // A read returns the latched flags and clears them
         ans = {8'h00, rd[15:8], (j < NUM_STAT) ? 8'hff : 8'h00};
      end
      hbse_spi_host_inst.frame(rd, 16);
      check("status after clear", {8'h00, hbse_spi_host_inst.rxWord},
            ans);
   endtask

   task automatic t_events();
      @(posedge clk);
      ocEvent <= 8'hff;
      olEvent <= 24'hffffff;
      repeat (20) @(posedge clk);
      ocEvent <= 8'h00;
      olEvent <= 24'h000000;
      settle();
      check("outputs after faults", {upperSwitchOn, lowerSwitchOn},
            expected());
   endtask

   task automatic t_reset_again();
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      for (int g = 0; g < NUM_CTRL; g++)
         shadow[g] = CTRL_RESET;
      settle();
      check("outputs after second reset", {upperSwitchOn, lowerSwitchOn},
            24'h000000);
      write_reg(2, 8'h2d);
      check("write after second reset", {upperSwitchOn, lowerSwitchOn},
            expected());
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      error_cnt = 0;
      n_checks  = 0;
      reset_n   = 1'b0;
      ocEvent   = 8'h00;
      olEvent   = 24'h000000;
      for (int g = 0; g < NUM_CTRL; g++)
         shadow[g] = CTRL_RESET;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_groups();
      t_read();
      t_partial();
      t_events();
      t_status();
      t_reset_again();
      close_out();
   end

   // Whole run is some thirty frames; this leaves ample margin
   initial
   begin
      #100000;
      error_cnt++;
      close_out();
   end
endmodule // test_half_bridge_switch_enable_regs
